//--- core/mbox_cmd_engine.sv
/*
  Mailbox command engine of the secure configuration manager: takes
  header-framed command packets, runs flash port commands, returns responses.
  Assumes all inputs come from logic on REF_CLK_I and a flash port that
  acknowledges each request with a one-cycle FLASH_ACK_I.
*/
// How it works
// - Hash query 0x14 takes one argument, answers three low hash words.
// - Hash words are little-endian, lowest byte in the lowest lane.
// - Code 0x32 claims the flash port; no arguments, no data, code only.
// - Status words 2-3 give first failing image; all ones means none.
// - Status word 4: major code high half, minor information low half.
// - Major codes 0xF001 to 0xF007 name the seven failure kinds.
// - Status words 6 and 7 hold error location and details, zero if none.
// - Code 0x33 releases the flash port claim; no arguments, no data.
// - Good read answers OK plus the words; a failure answers an error.
// - Partly failed reads still answer OK; failed words read as zero.
// - Erase 0x38 takes two words; address must be 64 KB aligned.
// - Codes 0, 1, 2, 3 and 0x100 mean ok, malformed, firmware_unsupported_code, unsupported, unconfigured.
// - Codes 0x1FF, 0x2FF, 0x3FF mean busy, no response, general error.
// - Length fields exclude the header word of every packet.
// - Header tag bits 27:24 are echoed from command to response.
`timescale 1ns/1ps
`include "mbox_defs.svh"
module mbox_cmd_engine #(
  parameter int MAX_XFER_WORDS = `XFER_WORDS
) (
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic CMD_VALID_I,
  input wire logic [31:0] CMD_DATA_I,
  output logic CMD_READY_O,
  output logic RSP_VALID_O,
  output logic [31:0] RSP_DATA_O,
  output logic RSP_LAST_O,
  input wire logic RSP_READY_I,
  input wire logic [95:0] HASH_I,
  input wire mbox_pkg::upd_status_t STATUS_I,
  input wire logic CONFIGURED_I,
  input wire logic CFG_BUSY_I,
  output mbox_pkg::flash_req_t FLASH_REQ_O,
  input wire logic FLASH_ACK_I,
  input wire logic FLASH_ERR_I,
  input wire logic [31:0] FLASH_RDATA_I,
  output logic FLASH_OPEN_O,
  output logic [3:0] FLASH_CS_O
);
  import mbox_pkg::*;

  // Response length field and write length check limit transfers
  if (MAX_XFER_WORDS < 1 || MAX_XFER_WORDS > 2045) begin : g_chk
    $error("MAX_XFER_WORDS out of range");
  end

  state_t st_r, st_nxt;
  logic [10:0] code_r, code_nxt, len_r, len_nxt, rem_r, rem_nxt;
  logic [10:0] idx_r, idx_nxt, rlen_r, rlen_nxt, rc_r, rc_nxt, chk;
  logic [3:0] id_r, id_nxt, cs_r, cs_nxt;
  logic [1:0] argn_r, argn_nxt;
  logic [31:0] arg0_r, arg0_nxt, arg1_r, arg1_nxt, rsp_r, rsp_nxt;
  logic open_r, open_nxt, ferr_r, ferr_nxt;
  flash_req_t freq_r, freq_nxt;
  logic is_flash, is_xfer;

  // Status and hash words by index; failure fields blank when none failed
  function automatic logic [31:0] info_word(input logic [10:0] i, input logic hash,
                                            input logic [95:0] h, input upd_status_t s);
    logic nofail;
    nofail = &s.fail_img;
    info_word = 32'h0000_0000;
    if (hash) begin
      info_word = h[32*i[1:0] +: 32];
    end else begin
      case (i[2:0])
        3'd0: info_word = s.cur_img[31:0];
        3'd1: info_word = s.cur_img[63:32];
        3'd2: info_word = s.fail_img[31:0];
        3'd3: info_word = s.fail_img[63:32];
        3'd4: info_word = nofail ? 32'h0000_0000 : {`MAJOR_BASE + {13'h0000, s.major_idx}, s.minor};
        3'd5: info_word = nofail ? 32'h0000_0000 : s.version;
        3'd6: info_word = nofail ? 32'h0000_0000 : s.err_loc;
        default: info_word = nofail ? 32'h0000_0000 : s.err_det;
      endcase
    end
  endfunction

  // Command checks, in priority order
  always_comb begin
    logic [31:0] exp_len;
    exp_len = 32'h0000_0000;
    is_flash = (code_r == `CMD_CS) || (code_r == `CMD_READ) || (code_r == `CMD_WRITE) ||
               (code_r == `CMD_ERASE) || (code_r == `CMD_CLOSE);
    is_xfer = (code_r == `CMD_READ) || (code_r == `CMD_WRITE);
    case (code_r)
      `CMD_HASH, `CMD_CS: exp_len = 32'h0000_0001;
      `CMD_READ, `CMD_ERASE: exp_len = 32'h0000_0002;
      `CMD_WRITE: exp_len = arg1_r + 32'h0000_0002;
      default: exp_len = 32'h0000_0000;
    endcase
    chk = `RC_OK;
    if (!(is_flash || code_r == `CMD_HASH || code_r == `CMD_STAT || code_r == `CMD_OPEN)) begin
      chk = `RC_UNRECOG;
    end else if ({21'h00_0000, len_r} != exp_len) begin
      chk = `RC_MALFORMED;
    end else if (code_r == `CMD_HASH && !CONFIGURED_I) begin
      chk = `RC_NOT_CFG;
    end else if (is_flash && !open_r) begin
      chk = `RC_GEN_ERR;
    end else if (code_r == `CMD_OPEN && open_r) begin
      chk = `RC_BUSY;
    end else if ((is_xfer || code_r == `CMD_ERASE) && CFG_BUSY_I) begin
      chk = `RC_BUSY;
    end else if (is_xfer && (arg0_r[1:0] != 2'b00 || arg1_r == 32'h0000_0000 ||
                             arg1_r > 32'(MAX_XFER_WORDS))) begin
      chk = `RC_MALFORMED;
    end else if (code_r == `CMD_ERASE && (arg0_r & `SECTOR_MASK) != 32'h0000_0000) begin
      chk = `RC_GEN_ERR;
    end else if (code_r == `CMD_ERASE && ((arg1_r & `ERASE_LSB_MASK) != 32'h0000_0000 ||
                                          arg1_r == 32'h0000_0000)) begin
      chk = `RC_MALFORMED;
    end
  end

  // Packet sequencer: next values
  always_comb begin
    st_nxt = st_r;
    code_nxt = code_r;
    len_nxt = len_r;
    rem_nxt = rem_r;
    idx_nxt = idx_r;
    rlen_nxt = rlen_r;
    rc_nxt = rc_r;
    id_nxt = id_r;
    cs_nxt = cs_r;
    argn_nxt = argn_r;
    arg0_nxt = arg0_r;
    arg1_nxt = arg1_r;
    rsp_nxt = rsp_r;
    open_nxt = open_r;
    ferr_nxt = ferr_r;
    freq_nxt = freq_r;
    CMD_READY_O = 1'b0;
    case (st_r)
      S_IDLE: begin
        CMD_READY_O = 1'b1;
        if (CMD_VALID_I) begin
          code_nxt = CMD_DATA_I[`CODE_W-1:0];
          id_nxt = CMD_DATA_I[`HDR_ID_LSB +: 4];
          len_nxt = CMD_DATA_I[`HDR_LEN_LSB +: `LEN_W];
          rem_nxt = CMD_DATA_I[`HDR_LEN_LSB +: `LEN_W];
          argn_nxt = 2'd0;
          idx_nxt = 11'h000;
          ferr_nxt = 1'b0;
          rlen_nxt = 11'h000;
          st_nxt = (CMD_DATA_I[`HDR_LEN_LSB +: `LEN_W] == 11'h000) ? S_EXEC : S_ARGS;
        end
      end
      S_ARGS: begin
        CMD_READY_O = 1'b1;
        if (CMD_VALID_I) begin
          if (argn_r == 2'd0) arg0_nxt = CMD_DATA_I;
          if (argn_r == 2'd1) arg1_nxt = CMD_DATA_I;
          argn_nxt = (argn_r == 2'd2) ? 2'd2 : argn_r + 2'd1;
          rem_nxt = rem_r - 11'h001;
          // Write data is not buffered: it streams once address and count are known
          if (rem_r == 11'h001 || (code_r == `CMD_WRITE && argn_r == 2'd1)) st_nxt = S_EXEC;
        end
      end
      S_EXEC: begin
        rc_nxt = chk;
        st_nxt = S_HDR;
        if (chk != `RC_OK) begin
          if (rem_r != 11'h000) st_nxt = S_DRAIN;
        end else begin
          case (code_r)
            `CMD_HASH: rlen_nxt = `HASH_WORDS;
            `CMD_STAT: rlen_nxt = `STAT_WORDS;
            `CMD_OPEN: open_nxt = 1'b1;
            `CMD_CLOSE: open_nxt = 1'b0;
            `CMD_CS: cs_nxt = arg0_r[31:28];
            `CMD_READ: rlen_nxt = arg1_r[10:0];
            `CMD_ERASE: begin
              freq_nxt = '{vld: 1'b1, op: OP_ERASE, addr: arg0_r, cnt: arg1_r, wdata: 32'h0000_0000};
              st_nxt = S_FLASH;
            end
            `CMD_WRITE: st_nxt = S_WDATA;
            default: st_nxt = S_HDR;
          endcase
        end
      end
      S_WDATA: begin
        CMD_READY_O = 1'b1;
        if (CMD_VALID_I) begin
          freq_nxt = '{vld: 1'b1, op: OP_WRITE, addr: arg0_r + {19'h0_0000, idx_r, 2'b00},
                       cnt: 32'h0000_0001, wdata: CMD_DATA_I};
          idx_nxt = idx_r + 11'h001;
          rem_nxt = rem_r - 11'h001;
          st_nxt = S_FLASH;
        end
      end
      S_FLASH: begin
        if (FLASH_ACK_I) begin
          freq_nxt.vld = 1'b0;
          if (code_r == `CMD_READ) begin
            // A failed word reads as zero, the answer stays OK
            rsp_nxt = FLASH_ERR_I ? 32'h0000_0000 : FLASH_RDATA_I;
            st_nxt = S_DATA;
          end else if (code_r == `CMD_WRITE && rem_r != 11'h000) begin
            ferr_nxt = ferr_r | FLASH_ERR_I;
            st_nxt = S_WDATA;
          end else begin
            rc_nxt = (ferr_r || FLASH_ERR_I) ? `RC_GEN_ERR : `RC_OK;
            idx_nxt = 11'h000;
            st_nxt = S_HDR;
          end
        end
      end
      S_DRAIN: begin
        CMD_READY_O = 1'b1;
        if (CMD_VALID_I) begin
          rem_nxt = rem_r - 11'h001;
          if (rem_r == 11'h001) st_nxt = S_HDR;
        end
      end
      S_HDR: begin
        if (RSP_READY_I) begin
          if (rlen_r == 11'h000) begin
            st_nxt = S_IDLE;
          end else if (code_r == `CMD_READ) begin
            freq_nxt = '{vld: 1'b1, op: OP_READ, addr: arg0_r, cnt: 32'h0000_0001, wdata: 32'h0000_0000};
            st_nxt = S_FLASH;
          end else begin
            st_nxt = S_DATA;
          end
        end
      end
      S_DATA: begin
        if (RSP_READY_I) begin
          idx_nxt = idx_r + 11'h001;
          if (idx_r == rlen_r - 11'h001) begin
            st_nxt = S_IDLE;
          end else if (code_r == `CMD_READ) begin
            freq_nxt = '{vld: 1'b1, op: OP_READ, addr: arg0_r + {19'h0_0000, idx_nxt, 2'b00},
                         cnt: 32'h0000_0001, wdata: 32'h0000_0000};
            st_nxt = S_FLASH;
          end
        end
      end
      default: st_nxt = S_IDLE;
    endcase
    // Output word is registered; built here from the values it will show
    if (st_nxt == S_HDR && st_r != S_HDR) begin
      rsp_nxt = {4'h0, id_r, 1'b0, rlen_nxt, 1'b0, rc_nxt};
    end else if (st_nxt == S_DATA && code_r != `CMD_READ) begin
      rsp_nxt = info_word(idx_nxt, code_r == `CMD_HASH, HASH_I, STATUS_I);
    end
  end

  // Packet sequencer: registers
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_r <= S_IDLE;
      code_r <= 11'h000;
      len_r <= 11'h000;
      rem_r <= 11'h000;
      idx_r <= 11'h000;
      rlen_r <= 11'h000;
      rc_r <= `RC_OK;
      id_r <= 4'h0;
      cs_r <= `CS_RST;
      argn_r <= 2'd0;
      arg0_r <= 32'h0000_0000;
      arg1_r <= 32'h0000_0000;
      rsp_r <= 32'h0000_0000;
      open_r <= 1'b0;
      ferr_r <= 1'b0;
      freq_r <= '0;
    end else begin
      st_r <= st_nxt;
      code_r <= code_nxt;
      len_r <= len_nxt;
      rem_r <= rem_nxt;
      idx_r <= idx_nxt;
      rlen_r <= rlen_nxt;
      rc_r <= rc_nxt;
      id_r <= id_nxt;
      cs_r <= cs_nxt;
      argn_r <= argn_nxt;
      arg0_r <= arg0_nxt;
      arg1_r <= arg1_nxt;
      rsp_r <= rsp_nxt;
      open_r <= open_nxt;
      ferr_r <= ferr_nxt;
      freq_r <= freq_nxt;
    end
  end

  // Outputs
  assign RSP_VALID_O = (st_r == S_HDR) || (st_r == S_DATA);
  assign RSP_LAST_O = ((st_r == S_HDR) && rlen_r == 11'h000) || ((st_r == S_DATA) && idx_r == rlen_r - 11'h001);
  assign RSP_DATA_O = rsp_r;
  assign FLASH_REQ_O = freq_r;
  assign FLASH_OPEN_O = open_r;
  assign FLASH_CS_O = cs_r;

  // Checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  a_hdr_tag_echo: assert property ((st_r == S_HDR) |-> RSP_DATA_O[27:24] == id_r)
    else $error("response tag differs from command tag");
  a_hdr_len_field: assert property ((st_r == S_HDR) |-> RSP_DATA_O[22:12] == rlen_r)
    else $error("response length field wrong");
  a_hash_three: assert property ((st_r == S_EXEC && code_r == `CMD_HASH && chk == `RC_OK) |=> rlen_r == 11'h003)
    else $error("hash answer not three words");
  a_hash_low_byte: assert property ((st_r == S_DATA && code_r == `CMD_HASH && idx_r == 11'h000)
    |-> RSP_DATA_O[7:0] == HASH_I[7:0])
    else $error("hash byte order wrong");
  a_nofail_blank: assert property ((st_r == S_DATA && code_r == `CMD_STAT && idx_r > 11'h003 && &STATUS_I.fail_img)
    |-> RSP_DATA_O == 32'h0000_0000)
    else $error("status words not blank without failure");
  a_major_code: assert property ((st_r == S_DATA && code_r == `CMD_STAT && idx_r == 11'h004 && !(&STATUS_I.fail_img))
    |-> RSP_DATA_O[31:16] == `MAJOR_BASE + {13'h0000, STATUS_I.major_idx})
    else $error("major error code wrong");
  a_open_claim: assert property ((st_r == S_EXEC && code_r == `CMD_OPEN && chk == `RC_OK) |=> open_r && st_r == S_HDR)
    else $error("claim not taken");
  a_close_release: assert property ((st_r == S_EXEC && code_r == `CMD_CLOSE && chk == `RC_OK) |=> !open_r)
    else $error("claim not released");
  a_erase_align: assert property (FLASH_REQ_O.vld && FLASH_REQ_O.op == OP_ERASE |-> FLASH_REQ_O.addr[15:0] == 16'h0000)
    else $error("unaligned erase issued");
  a_read_ok: assert property ((st_r == S_DATA && code_r == `CMD_READ) |-> rc_r == `RC_OK)
    else $error("read data sent with error code");
  a_busy_cfg: assert property ((st_r == S_EXEC && chk != `RC_UNRECOG && code_r == `CMD_READ && open_r && len_r == 11'h002
    && CFG_BUSY_I) |=> rc_r == `RC_BUSY)
    else $error("read during configuration not refused");
  c_hash: cover property (st_r == S_DATA && code_r == `CMD_HASH && RSP_LAST_O && RSP_READY_I);
  c_read: cover property (st_r == S_DATA && code_r == `CMD_READ && RSP_LAST_O && RSP_READY_I);
  c_write: cover property (st_r == S_HDR && code_r == `CMD_WRITE && rc_r == `RC_OK);
  c_drain: cover property (st_r == S_DRAIN ##1 st_r == S_HDR);
endmodule

//--- core/mbox_defs.svh
/*
  Constants for the mailbox command engine: codes, header fields, limits.
  Assumes inclusion by the package and the engine only.
*/
`ifndef MBOX_DEFS_SVH
`define MBOX_DEFS_SVH
// Header word layout
`define HDR_ID_LSB 24
`define HDR_LEN_LSB 12
`define CODE_W 11
`define LEN_W 11
// Command codes
`define CMD_HASH 11'h014
`define CMD_STAT 11'h05B
`define CMD_OPEN 11'h032
`define CMD_CLOSE 11'h033
`define CMD_CS 11'h034
`define CMD_READ 11'h03A
`define CMD_WRITE 11'h039
`define CMD_ERASE 11'h038
// Response codes
`define RC_OK 11'h000
`define RC_MALFORMED 11'h001
`define RC_UNRECOG 11'h002
`define RC_FW_UNSUP 11'h003
`define RC_NOT_CFG 11'h100
`define RC_BUSY 11'h1FF
`define RC_NO_RESP 11'h2FF
`define RC_GEN_ERR 11'h3FF
// Major failure codes are this base plus 1..7
`define MAJOR_BASE 16'hF000
`define MAJOR_LAST 16'hF007
// Status words, limits and reset values
`define STAT_WORDS 11'h008
`define HASH_WORDS 11'h003
`define XFER_WORDS 1024
`define ERASE_LSB_MASK 32'h0000_3FFF
`define SECTOR_MASK 32'h0000_FFFF
`define CS_RST 4'h0
`endif

//--- core/mbox_pkg.sv
/*
  Types shared by the mailbox command engine and its bench.
  Assumes mbox_defs.svh is on the include path.
*/
package mbox_pkg;
  // Engine states, one-hot
  typedef enum logic [7:0] {
    S_IDLE = 8'h01, S_ARGS = 8'h02, S_EXEC = 8'h04, S_WDATA = 8'h08,
    S_FLASH = 8'h10, S_DRAIN = 8'h20, S_HDR = 8'h40, S_DATA = 8'h80
  } state_t;
  typedef enum logic [1:0] {OP_READ = 2'h0, OP_WRITE = 2'h1, OP_ERASE = 2'h2} flash_op_t;
  // One request towards the flash port; held until acknowledged
  typedef struct packed {
    logic vld;
    flash_op_t op;
    logic [31:0] addr;
    logic [31:0] cnt;
    logic [31:0] wdata;
  } flash_req_t;
  // Remote update status as seen by the manager
  typedef struct packed {
    logic [63:0] cur_img;
    logic [63:0] fail_img;
    logic [2:0] major_idx;
    logic [15:0] minor;
    logic [31:0] version;
    logic [31:0] err_loc;
    logic [31:0] err_det;
  } upd_status_t;
endpackage

//--- sim/flash_model.sv
/*
  Flash port model: answers each held request once, promptly or slowly.
  Assumes one request outstanding, held until acknowledged.
*/
`timescale 1ns/1ps
module flash_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire mbox_pkg::flash_req_t req_i,
  input wire logic slow_i,
  input wire logic [31:0] bad_addr_i,
  output logic ack_o,
  output logic err_o,
  output logic [31:0] rdata_o,
  output logic [31:0] wr_addr_o,
  output logic [31:0] wr_data_o
);
  import mbox_pkg::*;
  logic [2:0] wait_r;
  // One ack per request; idle lines toggle so stale data never looks valid
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      wait_r <= 3'h0;
      wr_addr_o <= 32'h0000_0000;
      wr_data_o <= 32'h0000_0000;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      err_o <= ~err_o;
      rdata_o <= ~rdata_o;
      wait_r <= 3'h0;
    end else if (req_i.vld && wait_r == (slow_i ? 3'h5 : 3'h1)) begin
      ack_o <= 1'b1;
      err_o <= (req_i.addr == bad_addr_i);
      rdata_o <= ~req_i.addr; // Data tied to address so offsets are visible
      // Erase shows its count on the data lines so the bench can see it
      if (req_i.op != OP_READ) begin
        wr_addr_o <= req_i.addr;
        wr_data_o <= (req_i.op == OP_ERASE) ? req_i.cnt : req_i.wdata;
      end
    end else begin
      wait_r <= req_i.vld ? wait_r + 3'h1 : 3'h0;
      err_o <= ~err_o;
      rdata_o <= ~rdata_o;
    end
  end
endmodule

//--- sim/testbench.sv
/*
  Self-checking bench for the mailbox command engine.
  Assumes flash_model stands on the flash port; the bench plays the host.
*/
`timescale 1ns/1ps
module testbench;
  import mbox_pkg::*;
  logic clk, arst_n, cmd_vld, cmd_rdy, rsp_vld, rsp_last, rsp_rdy, cfgd, cfg_busy;
  logic fack, ferr, fopen, slow;
  logic [31:0] cmd_data, rsp_data, frdata, bad_addr, wr_addr, wr_data;
  logic [95:0] hash;
  logic [3:0] fcs;
  upd_status_t status;
  flash_req_t freq;
  logic [31:0] args [0:7];
  logic [31:0] rw [0:15];
  int fails, n_tests;

  mbox_cmd_engine #(.MAX_XFER_WORDS(4)) uut (.REF_CLK_I(clk), .ARST_N_I(arst_n), .CMD_VALID_I(cmd_vld),
    .CMD_DATA_I(cmd_data), .CMD_READY_O(cmd_rdy), .RSP_VALID_O(rsp_vld), .RSP_DATA_O(rsp_data),
    .RSP_LAST_O(rsp_last), .RSP_READY_I(rsp_rdy), .HASH_I(hash), .STATUS_I(status), .CONFIGURED_I(cfgd),
    .CFG_BUSY_I(cfg_busy), .FLASH_REQ_O(freq), .FLASH_ACK_I(fack), .FLASH_ERR_I(ferr),
    .FLASH_RDATA_I(frdata), .FLASH_OPEN_O(fopen), .FLASH_CS_O(fcs));
  flash_model flash (.clk_i(clk), .rst_n_i(arst_n), .req_i(freq), .slow_i(slow), .bad_addr_i(bad_addr),
    .ack_o(fack), .err_o(ferr), .rdata_o(frdata), .wr_addr_o(wr_addr), .wr_data_o(wr_data));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Header first, then arguments; each word held until taken
  task automatic send(input logic [31:0] h, input int n);
    int k;
    for (int i = 0; i <= n; i++) begin
      @(negedge clk);
      cmd_vld = 1'b1;
      cmd_data = (i == 0) ? h : args[i-1];
      k = 0;
      while (cmd_rdy !== 1'b1 && k < 2000) begin
        @(negedge clk);
        k++;
      end
      if (cmd_rdy !== 1'b1) fails++;
      @(posedge clk);
    end
    @(negedge clk);
    cmd_vld = 1'b0;
    cmd_data = ~cmd_data;
  endtask

  // Ready every other cycle, so the engine also sees stalls
  task automatic recv(output logic [31:0] h, output int n);
    int k;
    logic done;
    n = 0;
    k = 0;
    done = 1'b0;
    h = 32'hFFFF_FFFF;
    while (!done && k < 3000) begin
      @(negedge clk);
      k++;
      if (rsp_rdy) begin
        rsp_rdy = 1'b0;
      end else if (rsp_vld === 1'b1) begin
        if (n == 0) h = rsp_data;
        else if (n < 17) rw[n-1] = rsp_data;
        done = (rsp_last === 1'b1);
        n++;
        rsp_rdy = 1'b1;
      end
    end
    if (!done) fails++;
    @(negedge clk);
    rsp_rdy = 1'b0;
  endtask

  task automatic xfer(input logic [3:0] t, input logic [10:0] l, input logic [10:0] c, input int n,
                      input logic [10:0] rl, input logic [10:0] rc);
    logic [31:0] h;
    int got;
    send({4'h0, t, 1'b0, l, 1'b0, c}, n);
    recv(h, got);
    chk("response header", h, {4'h0, t, 1'b0, rl, 1'b0, rc});
    chk("response count", 32'(got), 32'(rl) + 32'd1);
  endtask

  task automatic t_hash;
    args[0] = 32'h0000_0000;
    cfgd = 1'b0;
    xfer(4'h3, 11'h001, 11'h014, 1, 11'h000, 11'h100);
    cfgd = 1'b1;
    xfer(4'hC, 11'h001, 11'h014, 1, 11'h003, 11'h000);
    for (int i = 0; i < 3; i++) chk("hash word", rw[i], hash[32*i +: 32]);
    chk("hash low word", rw[0], 32'h4755_e4db);
    chk("hash top word", rw[2], 32'h31eb_527e);
    $display("hash query done");
  endtask

  task automatic t_status;
    status.fail_img = 64'hFFFF_FFFF_FFFF_FFFF;
    xfer(4'h1, 11'h000, 11'h05B, 0, 11'h008, 11'h000);
    chk("current image low", rw[0], status.cur_img[31:0]);
    chk("fail image none", rw[3], 32'hFFFF_FFFF);
    chk("fail image none low", rw[2], 32'hFFFF_FFFF);
    for (int i = 4; i < 8; i++) chk("status unused", rw[i], 32'h0000_0000);
    for (int m = 1; m <= 7; m++) begin
      status.fail_img = 64'h0000_0000_0012_0000;
      status.major_idx = m[2:0];
      xfer(4'h2, 11'h000, 11'h05B, 0, 11'h008, 11'h000);
      chk("fail image", rw[2], 32'h0012_0000);
      chk("fail code", rw[4], {16'hF000 + 16'(m), status.minor});
      chk("error location", rw[6], status.err_loc);
      chk("error details", rw[7], status.err_det);
    end
    $display("status query done");
  endtask

  task automatic t_port;
    xfer(4'h2, 11'h000, 11'h033, 0, 11'h000, 11'h3FF);
    xfer(4'h3, 11'h000, 11'h032, 0, 11'h000, 11'h000);
    chk("port claimed", fopen, 1'b1);
    xfer(4'h4, 11'h000, 11'h032, 0, 11'h000, 11'h1FF);
    args[0] = 32'h2000_0000;
    xfer(4'h5, 11'h001, 11'h034, 1, 11'h000, 11'h000);
    chk("chip select", fcs, 4'h2);
    xfer(4'h6, 11'h000, 11'h033, 0, 11'h000, 11'h000);
    chk("port released", fopen, 1'b0);
    xfer(4'h7, 11'h000, 11'h032, 0, 11'h000, 11'h000);
    $display("port claim done");
  endtask

  task automatic t_read;
    bad_addr = 32'h0000_0104;
    slow = 1'b1;
    args[0] = 32'h0000_0100;
    args[1] = 32'h0000_0004;
    xfer(4'h8, 11'h002, 11'h03A, 2, 11'h004, 11'h000);
    for (int i = 0; i < 4; i++) chk("read word", rw[i], (i == 1) ? 32'h0 : ~(32'h100 + 32'(4 * i)));
    slow = 1'b0;
    args[1] = 32'h0000_0005;
    xfer(4'h9, 11'h002, 11'h03A, 2, 11'h000, 11'h001);
    args[1] = 32'h0000_0001;
    cfg_busy = 1'b1;
    xfer(4'hA, 11'h002, 11'h03A, 2, 11'h000, 11'h1FF);
    cfg_busy = 1'b0;
    args[0] = 32'h0000_0102;
    xfer(4'hB, 11'h002, 11'h03A, 2, 11'h000, 11'h001);
    xfer(4'hC, 11'h001, 11'h03A, 1, 11'h000, 11'h001);
    $display("flash read done");
  endtask

  task automatic t_write;
    args[0] = 32'h0001_0000;
    args[1] = 32'h0000_4000;
    xfer(4'hD, 11'h002, 11'h038, 2, 11'h000, 11'h000);
    chk("erase address", wr_addr, 32'h0001_0000);
    chk("erase count", wr_data, 32'h0000_4000);
    args[1] = 32'h0000_0002;
    args[2] = 32'hCAFE_0001;
    args[3] = 32'hCAFE_0002;
    xfer(4'hE, 11'h004, 11'h039, 4, 11'h000, 11'h000);
    chk("write address", wr_addr, 32'h0001_0004);
    chk("write data", wr_data, 32'hCAFE_0002);
    bad_addr = 32'h0001_0000;
    xfer(4'hF, 11'h004, 11'h039, 4, 11'h000, 11'h3FF);
    bad_addr = 32'hFFFF_FFFC;
    args[0] = 32'h0001_0004;
    args[1] = 32'h0000_4000;
    xfer(4'h1, 11'h002, 11'h038, 2, 11'h000, 11'h3FF);
    chk("no unaligned erase", wr_addr, 32'h0001_0004);
    args[0] = 32'h0001_0000;
    args[1] = 32'h0000_2000;
    xfer(4'h2, 11'h002, 11'h038, 2, 11'h000, 11'h001);
    // Misaligned write: the data words that follow must be drained
    args[0] = 32'h0001_0002;
    args[1] = 32'h0000_0002;
    xfer(4'h3, 11'h004, 11'h039, 4, 11'h000, 11'h001);
    chk("no misaligned write", wr_addr, 32'h0001_0004);
    $display("flash write and erase done");
  endtask

  task automatic t_firmware_unsupported_code;
    xfer(4'h5, 11'h002, 11'h07E, 2, 11'h000, 11'h002);
    args[0] = 32'h0000_0000;
    xfer(4'h6, 11'h001, 11'h014, 1, 11'h003, 11'h000);
    $display("firmware_unsupported_code code done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    fails = 0;
    n_tests = 0;
    arst_n = 1'b0;
    cmd_vld = 1'b0;
    cmd_data = 32'h0000_0000;
    rsp_rdy = 1'b0;
    cfgd = 1'b1;
    cfg_busy = 1'b0;
    slow = 1'b0;
    bad_addr = 32'hFFFF_FFFC;
    hash = 96'h31eb_527e_48bb_f630_4755_e4db;
    status = '{cur_img: 64'h0000_0000_0040_0000, fail_img: 64'hFFFF_FFFF_FFFF_FFFF, major_idx: 3'h1,
               minor: 16'h1234, version: 32'h0000_0001, err_loc: 32'h0000_0ABC, err_det: 32'h0000_0DEF};
    repeat (16) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk("idle ready", cmd_rdy, 1'b1);
    chk("idle valid", rsp_vld, 1'b0);
    t_hash();
    t_status();
    t_port();
    t_read();
    t_write();
    t_firmware_unsupported_code();
    close_out();
  end

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule
